//--- txpdo_map.vh
// Constants for the transmit process data object scheduler.
// Assumes a 100 MHz system clock and one object dictionary port.
`ifndef TXPDO_MAP_VH
`define TXPDO_MAP_VH

// ============================================================
// Object dictionary indices and sub-indices
`define COMM_INDEX 16'h1800
`define MAP_INDEX 16'h1A00
`define INDEX_CH_MASK 16'hFFFC
`define SUB_HIGHEST 8'h00
`define SUB_COB 8'h01
`define SUB_TTYPE 8'h02
`define SUB_INHIBIT 8'h03
`define SUB_COMPAT 8'h04
`define SUB_EVENT 8'h05
`define SUB_MAP_LAST 8'h08

// ============================================================
// Reset values
`define COMM_HIGHEST_RESET 8'h05
`define MAP_COUNT_RESET 8'h02
`define TTYPE_RESET 8'hFF
`define COB_BASE_CH1 11'h180
`define COB_BASE_CH2 11'h280
`define COB_BASE_CH3 11'h380
`define MAP_CH1_E1_RESET 32'h6041_0010
`define MAP_CH1_E2_RESET 32'h6044_0010

// ============================================================
// Identifier fields
`define COB_VALID_BIT 31
`define COB_FRAME_BIT 29
`define COB_KEEP_MASK 32'h8000_07FF

// ============================================================
// Transmission types
`define TT_SYNC_CHANGE 8'h00
`define TT_SYNC_MAX 8'hF0
`define TT_RESERVED_MAX 8'hFB
`define TT_SYNC_RTR 8'hFC
`define TT_ASYNC_RTR 8'hFD
`define TT_EVENT_MFR 8'hFE

// ============================================================
// Timing and sizes
`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define INHIBIT_UNIT_US 100
`define INHIBIT_PER_MS (1000 / `INHIBIT_UNIT_US)
`define MAX_ENTRIES 8
`define MAX_PAYLOAD_BITS 12'h040

`endif

//--- txpdo_channel.v
// One transmit channel: decides when to sample data and request a frame.
// Assumes a one-cycle millisecond tick and same-clock sync and request pulses.
`timescale 1ns/1ps
`include "txpdo_map.vh"

module txpdo_channel (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Timing and bus events
	input wire ms_tick,
	input wire sync_pulse,
	input wire rtr_hit,
	// Configuration
	input wire chan_enable,
	input wire [7:0] ttype,
	input wire [15:0] inhibit,
	input wire [15:0] event_time,
	// Data and hand-off
	input wire [63:0] app_data,
	input wire [63:0] data_mask,
	input wire grant,
	output wire send_req,
	output wire [63:0] frame_data
);

// ============================================================
// Decoding
reg pend_ff;
reg latched_ff;
reg [15:0] inh_cnt_ff;
reg [15:0] ev_cnt_ff;
reg [7:0] sync_cnt_ff;
reg [63:0] data_ff;
reg [63:0] last_ff;

// Millisecond resolution: the last decimal digit is dropped, so values below 10 give 0
wire [31:0] inhibit_div = inhibit / `INHIBIT_PER_MS;
wire [15:0] inhibit_ms = inhibit_div[15:0]; // [RULE_13] [RULE_14] [RULE_15]
wire [63:0] sample = app_data & data_mask;
wire changed = (sample != last_ff);
wire is_cyclic = (ttype != `TT_SYNC_CHANGE) && (ttype <= `TT_SYNC_MAX);
wire is_async = (ttype >= `TT_EVENT_MFR); // [RULE_11]
wire inh_clear = (inh_cnt_ff == 16'h0000);
// Event timer only expires with a nonzero inhibit value
wire ev_expire = is_async && ms_tick && (event_time != 16'h0000) && (inhibit != 16'h0000) &&
	(ev_cnt_ff <= 16'h0001); // [RULE_16] [RULE_17] [RULE_18]

// Asynchronous channels wait out the inhibit spacing before asking
assign send_req = pend_ff && chan_enable && (!is_async || inh_clear); // [RULE_12]
assign frame_data = data_ff;

// ============================================================
// Scheduling state
always @(posedge ref_clk) begin
	if (rst || !chan_enable) begin
		pend_ff <= 1'b0; // [RULE_02]
		latched_ff <= 1'b0;
		inh_cnt_ff <= 16'h0000;
		ev_cnt_ff <= 16'h0000;
		sync_cnt_ff <= 8'h00;
		data_ff <= 64'h0000_0000_0000_0000;
		last_ff <= 64'h0000_0000_0000_0000;
	end else begin
		// Timers restart at each accepted frame
		if (grant) begin
			pend_ff <= 1'b0;
			last_ff <= data_ff;
			inh_cnt_ff <= inhibit_ms; // [RULE_12]
			ev_cnt_ff <= event_time;
		end else if (ms_tick) begin
			if (!inh_clear)
				inh_cnt_ff <= inh_cnt_ff - 16'h0001;
			if (ev_cnt_ff <= 16'h0001)
				ev_cnt_ff <= event_time;
			else
				ev_cnt_ff <= ev_cnt_ff - 16'h0001;
		end
		// Triggers come after the grant so a new event is never lost
		if (ttype == `TT_SYNC_CHANGE) begin
			if (sync_pulse && changed) begin
				data_ff <= sample; // [RULE_07]
				pend_ff <= 1'b1;
			end
		end else if (is_cyclic) begin
			if (sync_pulse) begin
				if (sync_cnt_ff >= ttype - 8'h01) begin
					sync_cnt_ff <= 8'h00; // [RULE_25]
					data_ff <= sample; // [RULE_08]
					pend_ff <= 1'b1;
				end else begin
					sync_cnt_ff <= sync_cnt_ff + 8'h01;
				end
			end
		end else if (ttype == `TT_SYNC_RTR) begin
			if (sync_pulse) begin
				data_ff <= sample; // [RULE_09]
				latched_ff <= 1'b1;
			end
			if (rtr_hit && latched_ff)
				pend_ff <= 1'b1;
		end else if (ttype == `TT_ASYNC_RTR) begin
			if (rtr_hit) begin
				data_ff <= sample; // [RULE_10]
				pend_ff <= 1'b1;
			end
		end else if (is_async) begin
			// Latest value is tracked so the frame carries data current at send time
			data_ff <= sample;
			// Data already being taken is not a new change, or it would be sent twice
			if ((changed && !grant) || ev_expire)
				pend_ff <= 1'b1; // [RULE_11] [RULE_16]
		end
	end
end

endmodule // txpdo_channel

//--- txpdo_transmit_scheduler.v
// Transmit process data object scheduler with its object dictionary records.
// Assumes sync and remote request pulses from a CAN controller on the same clock,
// and a frame sink that accepts a frame with tx_valid and tx_ready.
`timescale 1ns/1ps
`include "txpdo_map.vh"

// Behaviour
// [RULE_01] Identifier defaults are 0x180, 0x280, 0x380 plus node identifier per channel.
// [RULE_02] Identifier bit 31 clear enables a channel; set disables all sending.
// [RULE_03] Identifier bit 29 must be zero; extended format writes are refused.
// [RULE_04] Identifier bits 10..0 form the transmitted frame identifier.
// [RULE_05] After reset channel one is valid, channels two and three not.
// [RULE_06] Transmission type resets to 255 and stays writable.
// [RULE_07] Type 0 samples on sync and sends only changed data.
// [RULE_08] Types 1..240 send every nth sync; 241..251 are rejected.
// [RULE_09] Type 252 latches on sync, sends on a following remote request.
// [RULE_10] Type 253 samples and sends on a remote request.
// [RULE_11] Types 254 and 255 both send on data change or event timer.
// [RULE_12] Asynchronous sends keep inhibit spacing; changes wait for it to end.
// [RULE_13] Inhibit value is 16 bits in 100 us units.
// [RULE_14] Inhibit applies at millisecond resolution, truncating the last digit.
// [RULE_15] Inhibit values below 10 mean no spacing.
// [RULE_16] Unchanged data is resent each time the event time elapses.
// [RULE_17] Event time is 16 bits in milliseconds.
// [RULE_18] With zero inhibit only data changes cause a send.
// [RULE_19] Any access to communication sub-index 4 answers with an abort.
// [RULE_20] Master invalidates a channel before writing its transmission type.
// [RULE_21] Mapping count defaults to 2, with eight writable 32-bit entries.
// [RULE_22] Mapped objects total at most eight payload bytes.
// [RULE_23] Master remaps via invalidate, count zero, entries, count, validate.
// [RULE_24] Entry holds index 31..16, sub-index 15..8, bit length 7..0.
// [RULE_25] Cyclic types keep a sync counter reloading after the programmed count.
module txpdo_transmit_scheduler #(
	parameter MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Node identity
	input wire [6:0] node_id,
	// Object dictionary access
	input wire od_req,
	input wire od_wr,
	input wire [15:0] od_index,
	input wire [7:0] od_subindex,
	input wire [31:0] od_wdata,
	output reg od_ack,
	output reg od_abort,
	output reg [31:0] od_rdata,
	// Bus events from the controller
	input wire sync_pulse,
	input wire rtr_valid,
	input wire [10:0] rtr_id,
	// Application data per channel
	input wire [63:0] app_data0,
	input wire [63:0] app_data1,
	input wire [63:0] app_data2,
	// Frame output
	output reg tx_valid,
	input wire tx_ready,
	output reg [10:0] tx_id,
	output reg [3:0] tx_dlc,
	output reg [63:0] tx_data
);

// ============================================================
// Storage
reg [31:0] cob_ff [0:2];
reg [7:0] ttype_ff [0:2];
reg [15:0] inhibit_ff [0:2];
reg [15:0] event_ff [0:2];
reg [7:0] count_ff [0:2];
reg [31:0] map_ff [0:23];
reg [16:0] tick_cnt_ff;
reg ms_tick_ff;
reg nxt_abort;
reg [31:0] nxt_rdata;
reg [2:0] grant_vec;
integer i;
integer j;

wire [191:0] app_bus = {app_data2, app_data1, app_data0};
wire [2:0] send_req;
wire [191:0] frame_bus;
wire [35:0] dlc_bus;
wire [32:0] id_bus;

// Sum of bit lengths of the first n entries of a mapping record
function [11:0] mapped_bits;
	input [1:0] ch;
	input [7:0] n;
	integer k;
	reg [11:0] acc;
	begin
		acc = 12'h000;
		for (k = 0; k < `MAX_ENTRIES; k = k + 1) begin
			if (k < n)
				acc = acc + {4'h0, map_ff[ch * `MAX_ENTRIES + k][7:0]}; // [RULE_24]
		end
		mapped_bits = acc;
	end
endfunction

// ============================================================
// Millisecond time base
// The counter covers the full default count; a short MS_CYCLES only suits simulation
always @(posedge ref_clk) begin
	if (rst) begin
		tick_cnt_ff <= 17'h0_0000;
		ms_tick_ff <= 1'b0;
	end else if (tick_cnt_ff == MS_CYCLES - 1) begin
		tick_cnt_ff <= 17'h0_0000;
		ms_tick_ff <= 1'b1;
	end else begin
		tick_cnt_ff <= tick_cnt_ff + 17'h0_0001;
		ms_tick_ff <= 1'b0;
	end
end

// ============================================================
// Object dictionary decode
// A fourth record index is not populated and falls through to an abort
wire comm_hit = ((od_index & `INDEX_CH_MASK) == `COMM_INDEX) && (od_index[1:0] != 2'b11);
wire map_hit = ((od_index & `INDEX_CH_MASK) == `MAP_INDEX) && (od_index[1:0] != 2'b11);
wire [1:0] od_ch = od_index[1:0];
// Slot is channel times eight plus sub-index minus one; sub-index 8 needs its bit 3
wire [4:0] map_slot = {od_ch, 3'b000} + {1'b0, od_subindex[3:0]} - 5'h01;
wire sub_is_entry = (od_subindex != 8'h00) && (od_subindex <= `SUB_MAP_LAST);
wire [7:0] wr_ttype = od_wdata[7:0];
wire ttype_reserved = (wr_ttype > `TT_SYNC_MAX) && (wr_ttype <= `TT_RESERVED_MAX);

// Answer and abort decision for the current access
always @* begin
	nxt_abort = 1'b0;
	nxt_rdata = 32'h0000_0000;
	if (comm_hit) begin
		case (od_subindex)
			`SUB_HIGHEST: begin
				nxt_rdata = {24'h00_0000, `COMM_HIGHEST_RESET};
				nxt_abort = od_wr; // Read-only
			end
			`SUB_COB: begin
				nxt_rdata = cob_ff[od_ch];
				nxt_abort = od_wr && od_wdata[`COB_FRAME_BIT]; // [RULE_03]
			end
			`SUB_TTYPE: begin
				nxt_rdata = {24'h00_0000, ttype_ff[od_ch]};
				// Type changes only on an invalidated channel, never to a reserved value
				nxt_abort = od_wr && (ttype_reserved || !cob_ff[od_ch][`COB_VALID_BIT]); // [RULE_08] [RULE_20]
			end
			`SUB_INHIBIT: begin
				nxt_rdata = {16'h0000, inhibit_ff[od_ch]};
			end
			`SUB_EVENT: begin
				nxt_rdata = {16'h0000, event_ff[od_ch]};
			end
			default: begin
				nxt_abort = 1'b1; // [RULE_19]
			end
		endcase
	end else if (map_hit) begin
		if (od_subindex == 8'h00) begin
			nxt_rdata = {24'h00_0000, count_ff[od_ch]};
			// Count above eight or a payload over eight bytes is refused
			nxt_abort = od_wr && ((od_wdata[7:0] > `MAX_ENTRIES) ||
				(mapped_bits(od_ch, od_wdata[7:0]) > `MAX_PAYLOAD_BITS)); // [RULE_22]
		end else if (sub_is_entry) begin
			nxt_rdata = map_ff[map_slot];
			// Entries change only while the mapping is deactivated
			nxt_abort = od_wr && (count_ff[od_ch] != 8'h00); // [RULE_23]
		end else begin
			nxt_abort = 1'b1;
		end
	end else begin
		nxt_abort = 1'b1; // Unmapped object
	end
end

wire wr_ok = od_req && od_wr && !nxt_abort;

// ============================================================
// Communication and mapping records
// A refused write leaves every record untouched, so the master may simply retry
always @(posedge ref_clk) begin
	if (rst) begin
		// Node identifier is taken while reset is held
		cob_ff[0] <= {21'h00_0000, `COB_BASE_CH1 + {4'h0, node_id}}; // [RULE_01] [RULE_05]
		cob_ff[1] <= {1'b1, 20'h0_0000, `COB_BASE_CH2 + {4'h0, node_id}}; // [RULE_01] [RULE_05]
		cob_ff[2] <= {1'b1, 20'h0_0000, `COB_BASE_CH3 + {4'h0, node_id}}; // [RULE_01] [RULE_05]
		for (i = 0; i < 3; i = i + 1) begin
			ttype_ff[i] <= `TTYPE_RESET; // [RULE_06]
			inhibit_ff[i] <= 16'h0000;
			event_ff[i] <= 16'h0000;
			count_ff[i] <= `MAP_COUNT_RESET; // [RULE_21]
		end
		for (i = 0; i < 24; i = i + 1)
			map_ff[i] <= 32'h0000_0000;
		map_ff[0] <= `MAP_CH1_E1_RESET;
		map_ff[1] <= `MAP_CH1_E2_RESET;
	end else if (wr_ok && comm_hit) begin
		case (od_subindex)
			`SUB_COB: cob_ff[od_ch] <= od_wdata & `COB_KEEP_MASK; // [RULE_02] [RULE_04]
			`SUB_TTYPE: ttype_ff[od_ch] <= wr_ttype; // [RULE_06]
			`SUB_INHIBIT: inhibit_ff[od_ch] <= od_wdata[15:0]; // [RULE_13]
			`SUB_EVENT: event_ff[od_ch] <= od_wdata[15:0]; // [RULE_17]
			default: ;
		endcase
	end else if (wr_ok && map_hit) begin
		if (od_subindex == 8'h00)
			count_ff[od_ch] <= od_wdata[7:0]; // [RULE_21]
		else
			map_ff[map_slot] <= od_wdata; // [RULE_21] [RULE_24]
	end
end

// One-cycle answer to every access
// Read data is zero on writes and refusals so stale record values never leak out
always @(posedge ref_clk) begin
	if (rst) begin
		od_ack <= 1'b0;
		od_abort <= 1'b0;
		od_rdata <= 32'h0000_0000;
	end else begin
		od_ack <= od_req;
		od_abort <= od_req && nxt_abort; // [RULE_19]
		od_rdata <= (od_req && !nxt_abort && !od_wr) ? nxt_rdata : 32'h0000_0000;
	end
end

// ============================================================
// Channel engines
genvar g;
generate
	for (g = 0; g < 3; g = g + 1) begin : chan
		localparam [1:0] CH_NUM = g;
		// The mask trims each payload to its mapped length, so unmapped bits stay zero
		wire [11:0] bits = mapped_bits(CH_NUM, count_ff[g]);
		// Length code rounds the mapped bits up to whole bytes
		wire [63:0] mask = (bits >= `MAX_PAYLOAD_BITS) ? {64{1'b1}} :
			((64'h0000_0000_0000_0001 << bits[5:0]) - 64'h0000_0000_0000_0001);
		wire [11:0] bytes = (bits + 12'h007) >> 3;
		wire enable = !cob_ff[g][`COB_VALID_BIT]; // [RULE_02]
		wire hit = rtr_valid && enable && (rtr_id == cob_ff[g][10:0]);

		assign dlc_bus[g * 12 +: 12] = bytes;
		assign id_bus[g * 11 +: 11] = cob_ff[g][10:0]; // [RULE_04]

		txpdo_channel u_chan (
			.ref_clk(ref_clk),
			.rst(rst),
			.ms_tick(ms_tick_ff),
			.sync_pulse(sync_pulse),
			.rtr_hit(hit),
			.chan_enable(enable),
			.ttype(ttype_ff[g]),
			.inhibit(inhibit_ff[g]),
			.event_time(event_ff[g]),
			.app_data(app_bus[g * 64 +: 64]),
			.data_mask(mask),
			.grant(grant_vec[g]),
			.send_req(send_req[g]),
			.frame_data(frame_bus[g * 64 +: 64])
		);
	end
endgenerate

// ============================================================
// Frame hand-off
// Fixed priority: channel one first, as its identifier also wins arbitration
// A new frame loads in the same cycle as the old one is taken, so no slot is lost
wire load = (!tx_valid || tx_ready) && (send_req != 3'b000);

// Only one channel is granted per load; the others keep their pending flags
always @* begin
	grant_vec = 3'b000;
	if (load) begin
		if (send_req[0])
			grant_vec = 3'b001;
		else if (send_req[1])
			grant_vec = 3'b010;
		else
			grant_vec = 3'b100;
	end
end

// Output frame register holds until the sink takes it
// The loop selects the single granted channel; at most one grant bit is set
always @(posedge ref_clk) begin
	if (rst) begin
		tx_valid <= 1'b0;
		tx_id <= 11'h000;
		tx_dlc <= 4'h0;
		tx_data <= 64'h0000_0000_0000_0000;
	end else if (load) begin
		tx_valid <= 1'b1;
		for (j = 0; j < 3; j = j + 1) begin
			if (grant_vec[j]) begin
				tx_id <= id_bus[j * 11 +: 11]; // [RULE_04]
				tx_dlc <= dlc_bus[j * 12 +: 4];
				tx_data <= frame_bus[j * 64 +: 64];
			end
		end
	end else if (tx_ready) begin
		tx_valid <= 1'b0;
	end
end

endmodule // txpdo_transmit_scheduler

//--- txpdo_properties.sv
// Port checker for the transmit scheduler.
// Assumes it is bound to the scheduler top and shares its clock.
`timescale 1ns/1ps
module txpdo_properties (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Dictionary port
	input wire od_req,
	input wire od_wr,
	input wire [15:0] od_index,
	input wire [7:0] od_subindex,
	input wire [31:0] od_wdata,
	input wire od_ack,
	input wire od_abort,
	input wire [31:0] od_rdata,
	// Frame port
	input wire tx_valid,
	input wire tx_ready,
	input wire [10:0] tx_id,
	input wire [3:0] tx_dlc,
	input wire [63:0] tx_data
);
	// ====
	// Shared clocking and decodes
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire comm = od_index[15:2] == 14'h0600 && od_index[1:0] != 2'h3;
	sequence s_res_type;
		od_req && od_wr && comm && od_subindex == 8'h02 && od_wdata[7:0] > 8'hF0 && od_wdata[7:0] < 8'hFC;
	endsequence
	sequence s_held;
		tx_valid && $stable(tx_id) && $stable(tx_dlc) && $stable(tx_data);
	endsequence
	// ====
	// Properties
	property p_ack; od_req |=> od_ack; endproperty
	property p_sub4; od_req && comm && od_subindex == 8'h04 |=> od_abort; endproperty
	property p_ext; od_req && od_wr && comm && od_subindex == 8'h01 && od_wdata[29] |=> od_abort; endproperty
	property p_res; s_res_type |=> od_abort; endproperty
	property p_clean; od_abort |-> od_ack && od_rdata == 32'h0000_0000; endproperty
	property p_hold; tx_valid && !tx_ready |=> s_held; endproperty
	property p_dlc; tx_valid |-> tx_dlc <= 4'h8; endproperty
	property p_pad; tx_valid |-> (tx_data >> {tx_dlc, 3'b000}) == 64'h0; endproperty
	a_ack: assert property (p_ack) else $error("access not answered next cycle");
	a_sub4: assert property (p_sub4) else $error("sub-index 4 access not refused");
	a_ext: assert property (p_ext) else $error("extended identifier accepted");
	a_res: assert property (p_res) else $error("reserved type accepted");
	a_clean: assert property (p_clean) else $error("refusal carried data");
	a_hold: assert property (p_hold) else $error("frame changed before accept");
	a_dlc: assert property (p_dlc) else $error("frame longer than eight bytes");
	a_pad: assert property (p_pad) else $error("payload beyond length not zero");
endmodule // txpdo_properties

//--- frame_sink.sv
// Frame sink model standing for the CAN controller side.
// Assumes frames are offered with tx_valid and held until tx_ready.
`timescale 1ns/1ps
module frame_sink (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Frame port
	input wire tx_valid,
	input wire [10:0] tx_id,
	input wire [3:0] tx_dlc,
	input wire [63:0] tx_data,
	input wire [3:0] stall,
	output reg tx_ready,
	// Capture
	output reg [7:0] frames,
	output reg [10:0] f_id,
	output reg [3:0] f_dlc,
	output reg [63:0] f_data
);
	reg [3:0] wait_ff;
	// Stalls each frame so the held-frame path is exercised
	always @(posedge ref_clk) begin
		if (rst) begin
			tx_ready <= 1'b0;
			wait_ff <= 4'h0;
			frames <= 8'h00;
		end else if (tx_valid && tx_ready) begin
			tx_ready <= 1'b0;
			wait_ff <= 4'h0;
			frames <= frames + 8'h01;
			f_id <= tx_id;
			f_dlc <= tx_dlc;
			f_data <= tx_data;
		end else if (tx_valid) begin
			wait_ff <= wait_ff + 4'h1;
			tx_ready <= wait_ff >= stall;
		end
	end
endmodule // frame_sink

//--- tb_top.sv
// Bench: dictionary table, then frame scheduling cases.
// Assumes the sink model and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
	// ====
	// Stimulus and observed signals
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg od_req = 1'b0;
	reg od_wr = 1'b0;
	reg [15:0] od_index = 16'h0000;
	reg [7:0] od_subindex = 8'h00;
	reg [31:0] od_wdata = 32'h0000_0000;
	reg sync_pulse = 1'b0;
	reg rtr_valid = 1'b0;
	reg [10:0] rtr_id = 11'h000;
	reg [63:0] app_data0 = 64'h0;
	reg [63:0] app_data1 = 64'h0;
	reg [63:0] app_data2 = 64'h0;
	wire od_ack, od_abort, tx_valid, tx_ready;
	wire [31:0] od_rdata;
	wire [10:0] tx_id, f_id;
	wire [3:0] tx_dlc, f_dlc;
	wire [63:0] tx_data, f_data;
	wire [7:0] frames;
	reg [59:0] rows [0:11];
	integer n_mismatch = 0;
	integer checks_done = 0;
	integer i;
	time t0;
	// Fast millisecond so timers fit in a short run
	txpdo_transmit_scheduler #(.MS_CYCLES(10)) dut (.ref_clk(ref_clk), .rst(rst), .node_id(7'h05),
		.od_req(od_req), .od_wr(od_wr), .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
		.od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata), .sync_pulse(sync_pulse),
		.rtr_valid(rtr_valid), .rtr_id(rtr_id), .app_data0(app_data0), .app_data1(app_data1),
		.app_data2(app_data2), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc),
		.tx_data(tx_data));
	frame_sink sink (.ref_clk(ref_clk), .rst(rst), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc),
		.tx_data(tx_data), .stall(4'h3), .tx_ready(tx_ready), .frames(frames), .f_id(f_id), .f_dlc(f_dlc),
		.f_data(f_data));
	// Clock
	always #5 ref_clk = ~ref_clk;
	// ====
	// Tasks
	task check(input [63:0] seen, input [63:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// One dictionary access; the answer is due exactly one cycle later
	task acc(input w, input [15:0] x, input [7:0] s, input [31:0] d, input ab, input [31:0] rd);
		begin
			@(posedge ref_clk);
			od_req <= 1'b1;
			od_wr <= w;
			od_index <= x;
			od_subindex <= s;
			od_wdata <= d;
			@(posedge ref_clk);
			od_req <= 1'b0;
			#1;
			check(od_ack, 1'b1);
			check(od_abort, ab);
			check(od_rdata, rd);
		end
	endtask
	// Sync or remote request pulse, then the frame count once it settles
	task sync_chk(input r, input [10:0] id, input [7:0] n);
		begin
			@(posedge ref_clk);
			sync_pulse <= !r;
			rtr_valid <= r;
			rtr_id <= id;
			@(posedge ref_clk);
			sync_pulse <= 1'b0;
			rtr_valid <= 1'b0;
			repeat (12) @(posedge ref_clk);
			#1;
			check(frames, n);
		end
	endtask
	task wait_frame(input [7:0] n);
		integer k;
		begin
			k = 0;
			while (frames != n && k < 200) begin
				@(posedge ref_clk);
				k = k + 1;
			end
			if (k == 200) begin
				n_mismatch = n_mismatch + 1;
				final_report;
			end
		end
	endtask
	// ====
	// Main sequence
	initial begin
		rows[0] = {16'h1800, 8'h00, 4'h0, 32'h0000_0005};
		rows[1] = {16'h1800, 8'h01, 4'h0, 32'h0000_0185};
		rows[2] = {16'h1801, 8'h01, 4'h0, 32'h8000_0285};
		rows[3] = {16'h1802, 8'h01, 4'h0, 32'h8000_0385};
		rows[4] = {16'h1802, 8'h02, 4'h0, 32'h0000_00FF};
		rows[5] = {16'h1800, 8'h03, 4'h0, 32'h0000_0000};
		rows[6] = {16'h1800, 8'h04, 4'h1, 32'h0000_0000};
		rows[7] = {16'h1A00, 8'h00, 4'h0, 32'h0000_0002};
		rows[8] = {16'h1A00, 8'h01, 4'h0, 32'h6041_0010};
		rows[9] = {16'h1A02, 8'h00, 4'h0, 32'h0000_0002};
		rows[10] = {16'h1803, 8'h00, 4'h1, 32'h0000_0000};
		rows[11] = {16'h1800, 8'h05, 4'h0, 32'h0000_0000};
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		check(tx_valid, 1'b0);
		check(od_ack, 1'b0);
		check(od_abort, 1'b0);
		check(od_rdata, 32'h0000_0000);
		for (i = 0; i < 12; i = i + 1)
			acc(1'b0, rows[i][59:44], rows[i][43:36], 32'h0, rows[i][32], rows[i][31:0]);
		acc(1'b1, 16'h1800, 8'h00, 32'h0000_0007, 1'b1, 32'h0);
		acc(1'b1, 16'h1800, 8'h04, 32'h0000_0001, 1'b1, 32'h0);
		check(frames, 8'h00);
		// Cyclic type 2 on channel one, including refused writes
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_0002, 1'b1, 32'h0);
		acc(1'b1, 16'h1800, 8'h01, 32'h8000_0185, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h01, 32'h2000_0185, 1'b1, 32'h0);
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_00F1, 1'b1, 32'h0);
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_00FB, 1'b1, 32'h0);
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_0002, 1'b0, 32'h0);
		acc(1'b0, 16'h1800, 8'h02, 32'h0, 1'b0, 32'h0000_0002);
		acc(1'b1, 16'h1800, 8'h01, 32'h0000_0185, 1'b0, 32'h0);
		@(posedge ref_clk);
		app_data0 <= 64'h1122_3344_5566_7788;
		for (i = 1; i <= 4; i = i + 1)
			sync_chk(1'b0, 11'h000, i / 2);
		check(f_id, 11'h185);
		check(f_data, 64'h5566_7788);
		check(f_dlc, 4'h4);
		// Type 0 sends only changed data
		acc(1'b1, 16'h1800, 8'h01, 32'h8000_0185, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_0000, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h01, 32'h0000_0185, 1'b0, 32'h0);
		@(posedge ref_clk);
		app_data0 <= 64'hABCD;
		sync_chk(1'b0, 11'h000, 8'h03);
		sync_chk(1'b0, 11'h000, 8'h03);
		// Type 252 sends the sync-latched data on a later request
		acc(1'b1, 16'h1800, 8'h01, 32'h8000_0185, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_00FC, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h01, 32'h0000_0185, 1'b0, 32'h0);
		sync_chk(1'b0, 11'h000, 8'h03);
		@(posedge ref_clk);
		app_data0 <= 64'h1234;
		sync_chk(1'b1, 11'h186, 8'h03);
		sync_chk(1'b1, 11'h185, 8'h04);
		check(f_data, 64'hABCD);
		// Remap channel two, then type 253 on remote request
		acc(1'b1, 16'h1A01, 8'h01, 32'h6064_0020, 1'b1, 32'h0);
		acc(1'b1, 16'h1A01, 8'h00, 32'h0000_0000, 1'b0, 32'h0);
		acc(1'b1, 16'h1A01, 8'h01, 32'h6064_0020, 1'b0, 32'h0);
		acc(1'b1, 16'h1A01, 8'h02, 32'h6064_0028, 1'b0, 32'h0);
		acc(1'b1, 16'h1A01, 8'h00, 32'h0000_0002, 1'b1, 32'h0);
		acc(1'b1, 16'h1A01, 8'h00, 32'h0000_0009, 1'b1, 32'h0);
		acc(1'b1, 16'h1A01, 8'h00, 32'h0000_0001, 1'b0, 32'h0);
		acc(1'b0, 16'h1A01, 8'h01, 32'h0, 1'b0, 32'h6064_0020);
		acc(1'b1, 16'h1801, 8'h02, 32'h0000_00FD, 1'b0, 32'h0);
		acc(1'b1, 16'h1801, 8'h01, 32'h0000_0285, 1'b0, 32'h0);
		@(posedge ref_clk);
		app_data1 <= 64'h9999_8888_7777_6666;
		sync_chk(1'b1, 11'h285, 8'h05);
		check(f_id, 11'h285);
		check(f_data, 64'h7777_6666);
		// Event-driven type 254 with inhibit 25, applied as 2 ms
		acc(1'b1, 16'h1800, 8'h01, 32'h8000_0185, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_00FE, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h03, 32'h0000_0019, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h01, 32'h0000_0185, 1'b0, 32'h0);
		repeat (60) @(posedge ref_clk);
		check(frames, 8'h06);
		i = frames;
		app_data0 <= 64'h55;
		wait_frame(i + 1);
		t0 = $time;
		app_data0 <= 64'h66;
		wait_frame(i + 2);
		check(f_data, 64'h66);
		check(($time - t0) / 10 > 10 && ($time - t0) / 10 < 22, 1'b1);
		// Unchanged data resent every 3 ms
		acc(1'b1, 16'h1800, 8'h05, 32'h0000_0003, 1'b0, 32'h0);
		wait_frame(i + 3);
		t0 = $time;
		wait_frame(i + 4);
		check(($time - t0) / 10 > 20 && ($time - t0) / 10 < 41, 1'b1);
		// Zero inhibit stops event timer sends; type 255 then sends like 254
		acc(1'b1, 16'h1800, 8'h03, 32'h0000_0000, 1'b0, 32'h0);
		repeat (60) @(posedge ref_clk);
		check(frames, i + 4);
		acc(1'b1, 16'h1800, 8'h01, 32'h8000_0185, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h02, 32'h0000_00FF, 1'b0, 32'h0);
		acc(1'b1, 16'h1800, 8'h01, 32'h0000_0185, 1'b0, 32'h0);
		wait_frame(i + 5);
		check(f_data, 64'h66);
		final_report;
	end
endmodule // tb_top
bind txpdo_transmit_scheduler txpdo_properties chk (.ref_clk(ref_clk), .rst(rst), .od_req(od_req), .od_wr(od_wr),
	.od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
	.od_rdata(od_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc),
	.tx_data(tx_data));
